// ### logic/sfc_map.svh
// Purpose: offsets, widths and timing counts of the sync serial flow-control block
// Assumes: 10 MHz core clock, external receive clock on its own port
// Notes: constants only, no logic
// What this block does
// - CTS low starts transfer clock and transmit
// - CTS sampled at frame start only
// - transfer clock resumes once CTS low again
// - RTS driven low when receiver ready
// - RTS high at first falling clock edge
// - three settings only: CTS, RTS, none
// - no flow control makes pin GPIO
// - RTS low again when frame completes
// - next frame accepted while buffer full
// - dummy transmit write arms reception in RTS
// - overrun when unread byte gets replaced
// - newest byte overwrites unread byte on overrun
// - overrun frame leaves receive request clear
// - overrun sets the overrun flag
// - continuous mode read arms next frame
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH

`define SFC_DATA_W 8
`define SFC_FIFO_DEPTH 8
`define SFC_FIFO_AW 3
`define SFC_LAST_BIT 3'h7
`define SFC_HALF_CYC 4'h1
`define SFC_RST_BYTE 8'h00

`endif

// ### logic/sfc_pkg.sv
// Purpose: types shared by the sync serial flow-control block
// Assumes: nothing
// Notes: codes written out
`default_nettype none
package sfc_pkg;

    typedef enum logic [1:0] {
        SFC_FC_NONE = 2'b00,
        SFC_FC_CTS = 2'b01,
        SFC_FC_RTS = 2'b10
    } sfc_fc_mode_type;

    typedef enum logic [1:0] {
        SFC_TX_IDLE = 2'b00,
        SFC_TX_LOW = 2'b01,
        SFC_TX_HIGH = 2'b10
    } sfc_tx_state_type;

endpackage
`default_nettype wire

// ### logic/sfc_fifo.sv
// Purpose: transmit buffer FIFO with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: read data comes from a register, with bypass when empty
`timescale 1ns/100ps
`default_nettype none
module sfc_fifo
    import sfc_pkg::*;
#(
    parameter int W = 8,
    parameter int D = 8,
    parameter int AW = 3
)
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_wr_valid,
    input wire logic [W-1:0] i_wr_data,
    output logic o_wr_ready,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [W-1:0] o_rd_data
);

    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW-1:0] rp_nxt;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic rdy_r;
    logic vld_r;
    logic [W-1:0] dat_r;
    logic push;
    logic pop;

    assign push = i_wr_valid && rdy_r;
    assign pop = i_rd_ready && vld_r;
    assign rp_nxt = rp_r + AW'(pop);
    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    assign o_wr_ready = rdy_r;
    assign o_rd_valid = vld_r;
    assign o_rd_data = dat_r;

    always_ff @(posedge i_core_clk)
    begin
        if (push)
        begin
            mem_r[wp_r] <= i_wr_data;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b0;
            vld_r <= 1'b0;
            dat_r <= '0;
        end
        else
        begin
            wp_r <= wp_r + AW'(push);
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= cnt_nxt != (AW+1)'(D);
            vld_r <= cnt_nxt != '0;
            // an entry written into an empty buffer is not in memory yet
            dat_r <= (push && wp_r == rp_nxt) ? i_wr_data : mem_r[rp_nxt];
        end
    end

endmodule // sfc_fifo
`default_nettype wire

// ### logic/sfc_sync_serial.sv
// Purpose: clock-synchronous serial channel with CTS/RTS flow control and overrun flag
// Assumes: transmit clock made here; receive clock comes from the far side
// Notes: receive shifter and start mark run on i_xfer_clk, all else on i_core_clk
`timescale 1ns/100ps
`include "sfc_map.svh"
`default_nettype none
module sfc_sync_serial
    import sfc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_xfer_clk,
    input wire logic i_rxd,
    input wire logic [1:0] i_fc_mode,
    input wire logic i_tx_en,
    input wire logic i_rx_en,
    input wire logic i_cont_mode,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_ready,
    input wire logic i_rx_read,
    output logic [7:0] o_rx_data,
    output logic o_rx_full,
    output logic o_rx_req,
    input wire logic i_rx_req_clr,
    output logic o_overrun,
    input wire logic i_overrun_clr,
    input wire logic i_fc_pin,
    output logic o_fc_pin,
    output logic o_fc_oe,
    input wire logic i_gpio_out,
    input wire logic i_gpio_dir,
    output logic o_gpio_in,
    output logic o_xfer_clk,
    output logic o_txd,
    output logic o_tx_busy
);

    function automatic sfc_fc_mode_type sfc_mode_of(input logic [1:0] code);
        case (code)
            2'b01: sfc_mode_of = SFC_FC_CTS;
            2'b10: sfc_mode_of = SFC_FC_RTS;
            default: sfc_mode_of = SFC_FC_NONE;
        endcase
    endfunction

    sfc_fc_mode_type mode;
    logic is_cts;
    logic is_rts;

    assign mode = sfc_mode_of(i_fc_mode);
    assign is_cts = mode == SFC_FC_CTS;
    assign is_rts = mode == SFC_FC_RTS;

    ////////////////////////////////////////////////////////////////////////////////
    // link side: receive shifter on the far side's clock

    logic [7:0] lk_sh_r;
    logic [7:0] lk_hold_r;
    logic [2:0] lk_cnt_r;
    logic lk_done_t_r;
    logic lk_start_t_r;

    always_ff @(posedge i_xfer_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            lk_sh_r <= '0;
            lk_hold_r <= `SFC_RST_BYTE;
            lk_cnt_r <= '0;
            lk_done_t_r <= 1'b0;
        end
        else
        begin
            lk_sh_r <= {i_rxd, lk_sh_r[7:1]};
            if (lk_cnt_r == `SFC_LAST_BIT)
            begin
                // byte ends on the rising edge of bit 8
                lk_cnt_r <= '0;
                lk_hold_r <= {i_rxd, lk_sh_r[7:1]};
                lk_done_t_r <= ~lk_done_t_r;
            end
            else
            begin
                lk_cnt_r <= lk_cnt_r + 3'h1;
            end
        end
    end

    // the clock may stop after a frame, so the start mark is a toggle
    always_ff @(negedge i_xfer_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            lk_start_t_r <= 1'b0;
        end
        else if (lk_cnt_r == 3'h0)
        begin
            lk_start_t_r <= ~lk_start_t_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // crossings: pin level, start toggle, done toggle

    logic [2:0] sy1_r;
    logic [2:0] sy2_r;
    logic [2:0] sy3_r;
    logic [2:0] lvl_r;
    logic [2:0] chg;
    logic cts_high;
    logic start_ev;
    logic done_ev;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sy1_r <= 3'h1;
            sy2_r <= 3'h1;
            sy3_r <= 3'h1;
            lvl_r <= 3'h1;
        end
        else
        begin
            sy1_r <= {lk_done_t_r, lk_start_t_r, i_fc_pin};
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            for (int i = 0; i < 3; i++)
            begin
                if (sy2_r[i] == sy3_r[i])
                begin
                    lvl_r[i] <= sy3_r[i];
                end
            end
        end
    end

    // toggles reset to 0 but lvl_r resets to 1: align the two event bits
    logic [2:0] base_r;
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            base_r <= 3'h0;
        end
        else
        begin
            base_r <= base_r ^ {chg[2:1], 1'b0};
        end
    end

    assign chg = (sy2_r ~^ sy3_r) & (sy3_r ^ {base_r[2:1], lvl_r[0]});
    assign cts_high = lvl_r[0];
    assign start_ev = chg[1];
    assign done_ev = chg[2];

    ////////////////////////////////////////////////////////////////////////////////
    // transmit buffer

    logic fifo_valid;
    logic [7:0] fifo_data;
    logic fifo_pop;
    logic tx_start;
    logic dummy_pop;
    sfc_tx_state_type st_r;

    // CTS level is looked at only while idle, never mid-frame
    assign tx_start = st_r == SFC_TX_IDLE && fifo_valid && i_tx_en && !is_rts
        && !(is_cts && cts_high);
    assign dummy_pop = is_rts && fifo_valid && i_tx_en && i_rx_en;
    assign fifo_pop = tx_start || dummy_pop;

    sfc_fifo #(
        .W(`SFC_DATA_W),
        .D(`SFC_FIFO_DEPTH),
        .AW(`SFC_FIFO_AW)
    ) u_txq (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_wr_valid(i_tx_valid),
        .i_wr_data(i_tx_data),
        .o_wr_ready(o_tx_ready),
        .o_rd_valid(fifo_valid),
        .i_rd_ready(fifo_pop),
        .o_rd_data(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // transmitter with own transfer clock, LSB first

    logic [3:0] div_r;
    logic [2:0] bit_r;
    logic [7:0] sh_r;
    logic clk_r;
    logic txd_r;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_r <= SFC_TX_IDLE;
            div_r <= '0;
            bit_r <= '0;
            sh_r <= '0;
            clk_r <= 1'b1;
            txd_r <= 1'b1;
        end
        else
        begin
            unique case (st_r)
                SFC_TX_IDLE:
                begin
                    if (tx_start)
                    begin
                        sh_r <= fifo_data;
                        txd_r <= fifo_data[0];
                        clk_r <= 1'b0;
                        div_r <= `SFC_HALF_CYC;
                        bit_r <= '0;
                        st_r <= SFC_TX_LOW;
                    end
                end
                SFC_TX_LOW:
                begin
                    if (div_r == 4'h0)
                    begin
                        clk_r <= 1'b1;
                        div_r <= `SFC_HALF_CYC;
                        st_r <= SFC_TX_HIGH;
                    end
                    else
                    begin
                        div_r <= div_r - 4'h1;
                    end
                end
                SFC_TX_HIGH:
                begin
                    if (div_r != 4'h0)
                    begin
                        div_r <= div_r - 4'h1;
                    end
                    else if (bit_r == `SFC_LAST_BIT)
                    begin
                        // frame always finishes; clock parks high
                        st_r <= SFC_TX_IDLE;
                    end
                    else
                    begin
                        bit_r <= bit_r + 3'h1;
                        sh_r <= {1'b1, sh_r[7:1]};
                        txd_r <= sh_r[1];
                        clk_r <= 1'b0;
                        div_r <= `SFC_HALF_CYC;
                        st_r <= SFC_TX_LOW;
                    end
                end
                default:
                begin
                    st_r <= SFC_TX_IDLE;
                end
            endcase
        end
    end

    // busy mirrors the next state, so the pin comes from a register
    logic busy_r;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            busy_r <= 1'b0;
        end
        else
        begin
            busy_r <= tx_start || st_r == SFC_TX_LOW
                || (st_r == SFC_TX_HIGH && (div_r != 4'h0 || bit_r != `SFC_LAST_BIT));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive buffer and flags

    logic rx_done;
    logic ovr_hit;
    logic [7:0] rx_buf_r;
    logic rx_full_r;
    logic rx_req_r;
    logic ovr_r;

    assign rx_done = done_ev && i_rx_en;
    // a read in the same cycle empties the buffer in time
    assign ovr_hit = rx_done && rx_full_r && !i_rx_read;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_buf_r <= `SFC_RST_BYTE;
            rx_full_r <= 1'b0;
        end
        else
        begin
            if (rx_done)
            begin
                // lk_hold_r is steady until the next frame ends
                rx_buf_r <= lk_hold_r;
            end
            rx_full_r <= rx_done || (rx_full_r && !i_rx_read);
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_req_r <= 1'b0;
        end
        else
        begin
            rx_req_r <= (rx_done && !ovr_hit) || (rx_req_r && !i_rx_req_clr);
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ovr_r <= 1'b0;
        end
        else
        begin
            ovr_r <= ovr_hit || (ovr_r && !i_overrun_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive-ready flag and shared flow-control pin

    logic armed_r;
    logic arm_ev;
    logic fc_pin_r;
    logic fc_oe_r;
    logic gpio_in_r;

    assign arm_ev = dummy_pop
        || (i_cont_mode && i_rx_read && i_tx_en && i_rx_en)
        || (is_rts && rx_done);

    // a start beats a late arm, but a short frame may start and end in one cycle
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            armed_r <= 1'b0;
        end
        else if (start_ev && !(is_rts && rx_done))
        begin
            armed_r <= 1'b0;
        end
        else if (arm_ev)
        begin
            armed_r <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            fc_pin_r <= 1'b1;
            fc_oe_r <= 1'b0;
            gpio_in_r <= 1'b1;
        end
        else
        begin
            gpio_in_r <= lvl_r[0];
            unique case (mode)
                SFC_FC_RTS:
                begin
                    fc_pin_r <= ~armed_r;
                    fc_oe_r <= 1'b1;
                end
                SFC_FC_CTS:
                begin
                    fc_pin_r <= 1'b1;
                    fc_oe_r <= 1'b0;
                end
                SFC_FC_NONE:
                begin
                    fc_pin_r <= i_gpio_out;
                    fc_oe_r <= i_gpio_dir;
                end
            endcase
        end
    end

    assign o_rx_data = rx_buf_r;
    assign o_rx_full = rx_full_r;
    assign o_rx_req = rx_req_r;
    assign o_overrun = ovr_r;
    assign o_fc_pin = fc_pin_r;
    assign o_fc_oe = fc_oe_r;
    assign o_gpio_in = gpio_in_r;
    assign o_xfer_clk = clk_r;
    assign o_txd = txd_r;
    assign o_tx_busy = busy_r;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    cts_start_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (st_r == SFC_TX_IDLE && is_cts && !cts_high && fifo_valid && i_tx_en)
        |=> (st_r == SFC_TX_LOW && !o_xfer_clk) ##1 st_r == SFC_TX_LOW)
        else $error("cts low did not start the transfer clock");

    cts_block_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (st_r == SFC_TX_IDLE && is_cts && cts_high) |=> st_r == SFC_TX_IDLE && o_xfer_clk)
        else $error("transfer clock ran while cts high");

    frame_runs_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (st_r == SFC_TX_LOW && bit_r == 3'h0 && $past(st_r) == SFC_TX_IDLE)
        |-> ##31 (st_r == SFC_TX_HIGH && bit_r == `SFC_LAST_BIT) ##1 st_r == SFC_TX_IDLE)
        else $error("frame did not finish in eight bits");

    rts_ready_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (is_rts && armed_r && !start_ev) |=> is_rts |-> (o_fc_oe && !o_fc_pin))
        else $error("rts not low while ready");

    rts_start_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (is_rts && start_ev && !rx_done) ##1 is_rts |-> ##1 o_fc_pin)
        else $error("rts not raised after frame start");

    cts_input_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        is_cts |=> !o_fc_oe || !$past(is_cts, 1))
        else $error("pin driven in cts mode");

    gpio_pin_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (mode == SFC_FC_NONE) |=> o_fc_oe == $past(i_gpio_dir) && o_fc_pin == $past(i_gpio_out))
        else $error("pin not following gpio controls");

    rts_rearm_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (is_rts && rx_done) |=> armed_r ##1 (!is_rts || !o_fc_pin))
        else $error("rts not low after frame end");

    dummy_arm_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (dummy_pop && !start_ev) |=> armed_r)
        else $error("dummy write did not arm reception");

    overrun_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ovr_hit |=> o_overrun && o_rx_full && o_rx_data == $past(lk_hold_r))
        else $error("overrun not flagged or byte not replaced");

    ovr_noreq_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ovr_hit && !o_rx_req) |=> !o_rx_req)
        else $error("receive request set on overrun");

    good_frame_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (rx_done && !rx_full_r) |=> o_rx_req && o_rx_full && !$rose(o_overrun))
        else $error("clean frame not reported");

    cont_arm_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_cont_mode && i_rx_read && i_tx_en && i_rx_en && !start_ev) |=> armed_r)
        else $error("read did not arm in continuous mode");

endmodule // sfc_sync_serial
`default_nettype wire

// ### dv/sfc_far_model.sv
// Purpose: far-side serial IC model for the sync serial flow-control block
// Assumes: its transfer clock idles high and runs only within frames
// Notes: captures transmitted bytes on the rising device clock
`timescale 1ns/100ps
`default_nettype none
module sfc_far_model
(
    input wire logic i_rst,
    input wire logic i_rts_n,
    input wire logic i_xfer_clk,
    input wire logic i_txd,
    output logic o_xfer_clk,
    output logic o_rxd,
    output logic o_line
);
    logic [7:0] sh_r;
    int cnt;
    logic [7:0] got_q[$];

    initial
    begin
        o_xfer_clk = 1'b1;
        o_rxd = 1'b1;
        o_line = 1'b1;
        cnt = 0;
        sh_r = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge i_xfer_clk)
    begin
        if (!i_rst)
        begin
            sh_r = {i_txd, sh_r[7:1]};
            cnt = cnt + 1;
            if (cnt == 8)
            begin
                got_q.push_back(sh_r);
                cnt = 0;
            end
        end
    end

    // low on this line lets the device transmit
    task automatic drive_line(input logic v);
        o_line = v;
    endtask

    task automatic send_byte(input logic [7:0] d, input logic slow, output logic ok);
        int k;
        for (k = 0; k < 500 && i_rts_n !== 1'b0; k++)
            #10;
        ok = (i_rts_n === 1'b0);
        if (ok)
        begin
            for (k = 0; k < 8; k++)
            begin
                o_xfer_clk = 1'b0;
                o_rxd = d[k];
                #3;
                if (slow && k == 0)
                    #2000;
                o_xfer_clk = 1'b1;
                #3;
            end
            // released data line must not keep showing the last bit
            o_rxd = ~d[7];
        end
    endtask
endmodule // sfc_far_model
`default_nettype wire

// ### dv/testbench.sv
// Purpose: self-checking bench for the sync serial flow-control block
// Assumes: far side is sfc_far_model; shared pin resolved here
// Notes: one task per scenario
`timescale 1ns/100ps
`default_nettype none
module testbench
    import sfc_pkg::*;
;
    logic clk, rst, far_clk, far_rxd, far_line, fc_wire, tx_en, rx_en, tx_valid, tx_ready;
    logic rx_read, rx_full, rx_req, req_clr, ovr, ovr_clr, fc_pin, fc_oe, gpio_out, gpio_dir;
    logic gpio_in, xclk, txd, busy, cont;
    logic [1:0] fc_mode;
    logic [7:0] tx_data, rx_data;
    int fails, comparisons;

    assign fc_wire = fc_oe ? fc_pin : far_line;

    sfc_sync_serial i_dut (.i_core_clk(clk), .i_rst(rst), .i_xfer_clk(far_clk),
        .i_rxd(far_rxd), .i_fc_mode(fc_mode), .i_tx_en(tx_en), .i_rx_en(rx_en),
        .i_cont_mode(cont), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
        .i_rx_read(rx_read), .o_rx_data(rx_data), .o_rx_full(rx_full), .o_rx_req(rx_req),
        .i_rx_req_clr(req_clr), .o_overrun(ovr), .i_overrun_clr(ovr_clr), .i_fc_pin(fc_wire),
        .o_fc_pin(fc_pin), .o_fc_oe(fc_oe), .i_gpio_out(gpio_out), .i_gpio_dir(gpio_dir),
        .o_gpio_in(gpio_in), .o_xfer_clk(xclk), .o_txd(txd), .o_tx_busy(busy));

    sfc_far_model i_far (.i_rst(rst), .i_rts_n(fc_wire), .i_xfer_clk(xclk), .i_txd(txd),
        .o_xfer_clk(far_clk), .o_rxd(far_rxd), .o_line(far_line));

    ////////////////////////////////////////////////////////////////////////
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic results();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic waited(string name, bit ok);
        check(name, {7'h00, ok}, 8'h01);
        if (!ok)
            results();
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_modes();
        int m;
        gpio_dir = 1'b1;
        for (m = 0; m < 4; m++)
        begin
            fc_mode = m[1:0];
            step(3);
            check("fc_oe", {7'h00, fc_oe}, {7'h00, m != 1});
        end
        fc_mode = SFC_FC_NONE;
        for (m = 0; m < 2; m++)
        begin
            gpio_out = m[0];
            step(3);
            check("gpio_drive", {6'h00, fc_oe, fc_pin}, {6'h01, m[0]});
        end
        gpio_dir = 1'b0;
        for (m = 0; m < 3; m++)
        begin
            i_far.drive_line(m[0]);
            step(7);
            check("gpio_read", {6'h00, fc_oe, gpio_in}, {7'h00, m[0]});
        end
        $display("test modes done");
    endtask

    task automatic test_cts_tx();
        int k;
        i_far.drive_line(1'b1);
        fc_mode = SFC_FC_CTS;
        tx_en = 1'b1;
        step(6);
        tx_valid = 1'b1;
        // ninth write lands on a full buffer and is dropped
        for (k = 0; k < 9; k++)
        begin
            tx_data = 8'h5A ^ 8'(k * 19);
            step(1);
        end
        tx_valid = 1'b0;
        check("tx_ready_full", {7'h00, tx_ready}, 8'h00);
        check("busy_cts_high", {7'h00, busy}, 8'h00);
        i_far.drive_line(1'b0);
        for (k = 0; k < 10 && busy !== 1'b1; k++)
            step(1);
        waited("cts_start", busy === 1'b1);
        step(4);
        i_far.drive_line(1'b1);
        for (k = 0; k < 60 && busy !== 1'b0; k++)
            step(1);
        waited("frame_end", busy === 1'b0);
        step(12);
        check("halted", {7'h00, busy}, 8'h00);
        check("frames_sent", 8'(i_far.got_q.size()), 8'h01);
        i_far.drive_line(1'b0);
        for (k = 0; k < 400 && i_far.got_q.size() < 8; k++)
            step(1);
        waited("drain", i_far.got_q.size() == 8);
        for (k = 0; k < 8; k++)
            check("tx_byte", i_far.got_q[k], 8'h5A ^ 8'(k * 19));
        step(2);
        check("tx_ready_empty", {7'h00, tx_ready}, 8'h01);
        $display("test cts_tx done");
    endtask

    task automatic test_rts_rx();
        int k;
        logic ok, hi;
        i_far.drive_line(1'b1);
        fc_mode = SFC_FC_RTS;
        rx_en = 1'b1;
        step(3);
        check("rts_idle", {6'h00, fc_oe, fc_pin}, 8'h03);
        tx_valid = 1'b1;
        step(1);
        tx_valid = 1'b0;
        for (k = 0; k < 20 && fc_pin !== 1'b0; k++)
            step(1);
        waited("rts_armed", fc_pin === 1'b0);
        hi = 1'b0;
        fork
            i_far.send_byte(8'h3C, 1'b1, ok);
            for (k = 0; k < 30 && !hi; k++)
            begin
                step(1);
                hi = (fc_pin === 1'b1);
            end
        join
        check("rts_high", {7'h00, hi}, 8'h01);
        waited("rts_gate", ok);
        for (k = 0; k < 20 && rx_full !== 1'b1; k++)
            step(1);
        waited("rx_done", rx_full === 1'b1);
        check("rx_data", rx_data, 8'h3C);
        check("rx_flags", {6'h00, rx_req, ovr}, 8'h02);
        for (k = 0; k < 20 && fc_pin !== 1'b0; k++)
            step(1);
        waited("rts_rearm", fc_pin === 1'b0);
        req_clr = 1'b1;
        step(1);
        req_clr = 1'b0;
        step(8);
        i_far.send_byte(8'hC3, 1'b0, ok);
        waited("rts_gate2", ok);
        for (k = 0; k < 20 && ovr !== 1'b1; k++)
            step(1);
        waited("overrun", ovr === 1'b1);
        check("rx_newest", rx_data, 8'hC3);
        check("req_after_ovr", {6'h00, rx_req, rx_full}, 8'h01);
        for (k = 0; k < 10 && fc_pin !== 1'b0; k++)
            step(1);
        waited("rts_after_fast", fc_pin === 1'b0);
        rx_read = 1'b1;
        ovr_clr = 1'b1;
        step(1);
        rx_read = 1'b0;
        ovr_clr = 1'b0;
        step(2);
        check("read_clear", {6'h00, rx_full, ovr}, 8'h00);
        $display("test rts_rx done");
    endtask

    task automatic test_cont();
        int k;
        logic ok, lo;
        cont = 1'b1;
        lo = 1'b0;
        fork
            i_far.send_byte(8'hA5, 1'b1, ok);
            begin
                for (k = 0; k < 15 && fc_pin !== 1'b1; k++)
                    step(1);
                check("cont_rts_high", {7'h00, fc_pin}, 8'h01);
                rx_read = 1'b1;
                step(1);
                rx_read = 1'b0;
                for (k = 0; k < 4 && !lo; k++)
                begin
                    step(1);
                    lo = (fc_pin === 1'b0);
                end
            end
        join
        check("cont_arm", {7'h00, lo}, 8'h01);
        waited("cont_gate", ok);
        for (k = 0; k < 20 && rx_full !== 1'b1; k++)
            step(1);
        waited("cont_done", rx_full === 1'b1);
        check("cont_data", rx_data, 8'hA5);
        check("cont_flags", {6'h00, rx_req, ovr}, 8'h02);
        cont = 1'b0;
        $display("test cont done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        #3000000;
        fails++;
        $display("Error watchdog expected finish seen hang");
        results();
    end

    initial
    begin
        fails = 0;
        comparisons = 0;
        cont = 1'b0;
        {rst, tx_en, rx_en, tx_valid, rx_read, req_clr, ovr_clr} = 7'h40;
        {gpio_out, gpio_dir, fc_mode, tx_data} = 12'h000;
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        step(2);
        check("reset_outs", {tx_ready, fc_oe, xclk, txd, rx_full, rx_req, ovr, busy}, 8'hB0);
        test_modes();
        test_cts_tx();
        test_rts_rx();
        test_cont();
        results();
    end
endmodule // testbench
`default_nettype wire
